// ---- cmd_resp_pkg.sv ----
`default_nettype none
package cmd_resp_pkg;
   // ==========================================================
   // Command words
   localparam logic [15:0] CMD_NULL    = 16'h0000;
   localparam logic [15:0] CMD_RESET   = 16'h0011;
   localparam logic [15:0] CMD_STANDBY = 16'h0022;
   localparam logic [15:0] CMD_WAKEUP  = 16'h0033;
   localparam logic [15:0] CMD_LOCK    = 16'h0555;
   localparam logic [15:0] CMD_UNLOCK  = 16'h0655;
   // ==========================================================
   // Opcode prefixes in bits 15:13
   localparam logic [2:0]  PFX_READ    = 3'h1;
   localparam logic [2:0]  PFX_WRITE   = 3'h2;
   localparam logic [2:0]  PFX_MULTI   = 3'h3;
   localparam logic [7:0]  READY_HI    = 8'hFF;
   // ==========================================================
   // Register space
   localparam logic [4:0]  ADDR_FAULT  = 5'h02;
   localparam logic [4:0]  ADDR_LAST   = 5'h14;
   localparam logic [4:0]  ADDR_WR_LO  = 5'h0B;
   localparam logic [4:0]  ADDR_CHAN   = 5'h0F;
   localparam int          NUM_REGS    = 21;
   // Identifier byte, arbitrary neutral value
   localparam logic [7:0]  DEVICE_ID   = 8'h04;
   localparam logic [7:0]  REV_ID      = 8'h01;
   localparam logic [7:0]  RST_0B      = 8'h60;
   localparam logic [7:0]  RST_0C      = 8'h3C;
   localparam logic [7:0]  RST_0D      = 8'h08;
   localparam logic [7:0]  RST_0E      = 8'h86;
   // ==========================================================
   // Word width selection
   localparam logic [1:0]  WS_16       = 2'h0;
   localparam logic [1:0]  WS_24       = 2'h1;
   localparam logic [1:0]  WS_32       = 2'h2;
   localparam int          RESET_CYC   = 4;

   typedef enum logic [2:0] {
      ST_READY, ST_LOCKED, ST_ACTIVE, ST_STANDBY, ST_RESETTING
   } mode_t;
endpackage : cmd_resp_pkg
`default_nettype wire

// ---- reg_store.sv ----
`default_nettype none
module reg_store
   import cmd_resp_pkg::*;
(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rstn,
   // Soft reset and write port
   input  wire logic       soft_rst,
   input  wire logic       wr_en,
   input  wire logic [4:0] wr_addr,
   input  wire logic [7:0] wr_data,
   // Read port
   input  wire logic [4:0] rd_addr,
   output logic      [7:0] rd_data
);
   logic [7:0] mem_q [NUM_REGS];

   // ==========================================================
   // Default values
   function automatic logic [7:0] dflt(input int i);
      case (i)
         0:       dflt = DEVICE_ID;
         1:       dflt = REV_ID;
         11:      dflt = RST_0B;
         12:      dflt = RST_0C;
         13:      dflt = RST_0D;
         14:      dflt = RST_0E;
         default: dflt = 8'h00;
      endcase
   endfunction : dflt

   genvar g;
   generate
      for (g = 0; g < NUM_REGS; g++) begin : g_reg
         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
               mem_q[g] <= dflt(g);
            end else if (soft_rst) begin
               mem_q[g] <= dflt(g); // [RULE11]
            end else if (wr_en && wr_addr == 5'(g) && wr_addr >= ADDR_WR_LO) begin
               mem_q[g] <= wr_data;
            end
         end
      end
   endgenerate

   // Beyond the last address reads zero
   always_comb begin
      if (rd_addr > ADDR_LAST) begin
         rd_data = 8'h00; // [RULE9]
      end else begin
         rd_data = mem_q[rd_addr];
      end
   end
endmodule : reg_store
`default_nettype wire

// ---- cmd_responder.sv ----
`default_nettype none
// Functional notes
// RULE1: first device word of every frame carries a status response
// RULE2: ready and standby-ready output FF in high byte, device id low
// RULE3: in ready state a frame is a single word
// RULE4: after ready, only unlock is honoured
// RULE5: executed commands echo the received word; null never echoes
// RULE6: single read or write answers 001, address, data
// RULE7: null changes nothing and reads back fault register 02h
// RULE8: multi read answers 011, address, count-1, then two regs per word
// RULE9: nonexistent registers read as zero bytes
// RULE10: commands ignored while a multi read response is pending
// RULE11: reset after frame end, defaults restored, ready word out
// RULE12: standby halts conversions, registers still accessible
// RULE13: enable bits written in standby apply only after wakeup; here they also apply when lock leaves standby
// RULE14: standby answered with 0022h
// RULE15: host disables channels before standby
// RULE16: wakeup leaves standby, answered with 0033h
// RULE17: host re-enables channels and waits before wakeup
// RULE18: locked state accepts only unlock, null, reads
// RULE19: lock answers 0555h then fault register readback
// RULE20: unlock answers 0655h, full access next frame
// RULE21: no commands during power-up; ready word then unlock
// RULE22: single read is 001 plus address and zero byte
// RULE23: decode at frame end, answer in next frame's first word
// RULE24: fixed command codes, 16 MSBs of first word
// RULE25: status in 16 MSBs, lower bits zero
module cmd_responder
   import cmd_resp_pkg::*;
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rstn,
   // Frame interface from the serial shifter
   input  wire logic        frame_end,
   input  wire logic [31:0] cmd_word,
   input  wire logic [1:0]  word_size,
   input  wire logic        power_ok,
   // Response to the serial shifter
   output logic      [31:0] resp_word,
   output logic             single_word,
   // Converter control
   output logic             conv_run,
   output logic      [7:0]  chan_enable,
   output logic             locked
);
   import cmd_resp_pkg::*;

   // ==========================================================
   // State
   mode_t       mode_q,  mode_d;
   logic [15:0] resp_q,  resp_d;
   logic [4:0]  mr_addr_q, mr_addr_d;
   logic [8:0]  mr_left_q, mr_left_d;
   logic [2:0]  rst_cnt_q;
   logic        pwr_s1_q, pwr_s2_q;
   logic [7:0]  chan_shadow_q;
   logic [7:0]  chan_enable_q;

   logic [15:0] cmd;
   logic [2:0]  pfx;
   logic [4:0]  cmd_addr;
   logic        wr_en;
   logic        soft_rst;
   logic [4:0]  rd_addr;
   logic [7:0]  rd_data;
   logic [7:0]  rd_data2;
   logic [4:0]  rd_addr2;

   assign cmd      = cmd_word[31:16]; // [RULE24]
   assign pfx      = cmd[15:13];
   assign cmd_addr = cmd[12:8];

   // ==========================================================
   // Command classification, used for lock filter and execution
   // A read with a nonzero count byte asks for several registers
   function automatic logic is_multi(input logic [15:0] c);
      is_multi = (c[15:13] == PFX_READ) && (c[7:0] != 8'h00);
   endfunction : is_multi

   function automatic logic lock_ok(input logic [15:0] c);
      lock_ok = (c == CMD_UNLOCK) || (c == CMD_NULL) || (c[15:13] == PFX_READ); // [RULE18]
   endfunction : lock_ok

   // Power-good is a pin; synchronise before use
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pwr_s1_q <= 1'b0;
         pwr_s2_q <= 1'b0;
      end else begin
         pwr_s1_q <= power_ok;
         pwr_s2_q <= pwr_s1_q;
      end
   end

   // ==========================================================
   // Register storage
   reg_store u_regs (
      .clock    (clock),
      .rstn     (rstn),
      .soft_rst (soft_rst),
      .wr_en    (wr_en),
      .wr_addr  (cmd_addr),
      .wr_data  (cmd[7:0]),
      .rd_addr  (rd_addr),
      .rd_data  (rd_data)
   );

   // Second read port for the paired multi-read word
   reg_store u_regs_b (
      .clock    (clock),
      .rstn     (rstn),
      .soft_rst (soft_rst),
      .wr_en    (wr_en),
      .wr_addr  (cmd_addr),
      .wr_data  (cmd[7:0]),
      .rd_addr  (rd_addr2),
      .rd_data  (rd_data2)
   );

   // Both read ports saturate at the top so a long read never wraps onto real registers
   assign rd_addr2 = (mr_addr_q == 5'h1F) ? 5'h1F : 5'(mr_addr_q + 5'h01); // [RULE9]
   // Null and refused commands read back the fault register
   assign rd_addr  = (mr_left_q != 9'h000) ? mr_addr_q
                   : (pfx == PFX_READ || (pfx == PFX_WRITE && mode_q != ST_LOCKED)) ? cmd_addr
                   : ADDR_FAULT; // [RULE7] [RULE19]

   // ==========================================================
   // Command decode, applied at frame end
   always_comb begin
      mode_d     = mode_q;
      resp_d     = resp_q;
      mr_addr_d  = mr_addr_q;
      mr_left_d  = mr_left_q;
      wr_en      = 1'b0;
      soft_rst   = 1'b0;
      if (mode_q == ST_RESETTING) begin
         if (rst_cnt_q == 3'(RESET_CYC - 1) && pwr_s2_q) begin
            mode_d = ST_READY;
            resp_d = {READY_HI, DEVICE_ID}; // [RULE2] [RULE11] [RULE21]
         end
      end else if (frame_end) begin // [RULE23]
         if (mr_left_q != 9'h000) begin
            // Pending multi read: new commands are dropped
            resp_d    = {rd_data, (mr_left_q > 9'h001) ? rd_data2 : 8'h00}; // [RULE8] [RULE10]
            mr_addr_d = (mr_addr_q > 5'h1C) ? 5'h1E : 5'(mr_addr_q + 5'h02);
            mr_left_d = (mr_left_q > 9'h002) ? 9'(mr_left_q - 9'h002) : 9'h000;
         end else if (mode_q == ST_READY) begin
            if (cmd == CMD_UNLOCK) begin // [RULE4] [RULE21]
               mode_d = ST_ACTIVE;
               resp_d = CMD_UNLOCK;
            end
         end else if (mode_q == ST_LOCKED && !lock_ok(cmd)) begin
            resp_d = {PFX_READ, ADDR_FAULT, rd_data}; // [RULE18] [RULE19]
         end else if (cmd == CMD_NULL) begin
            resp_d  = {PFX_READ, ADDR_FAULT, rd_data}; // [RULE7]
         end else if (cmd == CMD_UNLOCK) begin
            mode_d = (mode_q == ST_STANDBY) ? ST_STANDBY : ST_ACTIVE; // [RULE20]
            resp_d = CMD_UNLOCK;
         end else if (cmd == CMD_LOCK) begin
            mode_d     = ST_LOCKED;
            resp_d     = CMD_LOCK; // [RULE19]
         end else if (cmd == CMD_RESET) begin
            mode_d   = ST_RESETTING; // [RULE11]
            soft_rst = 1'b1;
         end else if (cmd == CMD_STANDBY) begin
            mode_d = ST_STANDBY; // [RULE12]
            resp_d = CMD_STANDBY; // [RULE14] [RULE5]
         end else if (cmd == CMD_WAKEUP) begin
            mode_d = ST_ACTIVE; // [RULE16]
            resp_d = CMD_WAKEUP; // [RULE5]
         end else if (pfx == PFX_READ && !is_multi(cmd)) begin
            resp_d = {PFX_READ, cmd_addr, rd_data}; // [RULE6] [RULE22]
         end else if (pfx == PFX_WRITE) begin
            // Read-only and missing addresses answer what is really stored
            wr_en  = 1'b1;
            resp_d = {PFX_READ, cmd_addr, // [RULE6]
                      (cmd_addr >= ADDR_WR_LO && cmd_addr <= ADDR_LAST) ? cmd[7:0] : rd_data};
         end else if (is_multi(cmd)) begin
            resp_d    = {PFX_MULTI, cmd_addr, cmd[7:0]}; // [RULE8]
            mr_addr_d = cmd_addr;
            mr_left_d = 9'(cmd[7:0]) + 9'h001;
         end
      end
   end

   // ==========================================================
   // State registers
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         mode_q <= ST_RESETTING;
         resp_q <= 16'h0000;
      end else begin
         mode_q <= mode_d;
         resp_q <= resp_d;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         mr_addr_q  <= 5'h00;
         mr_left_q  <= 9'h000;
      end else begin
         mr_addr_q  <= soft_rst ? 5'h00 : mr_addr_d;
         mr_left_q  <= soft_rst ? 9'h000 : mr_left_d;
      end
   end

   // Reset sequencing counter; holds the device until power is good
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rst_cnt_q <= 3'h0;
      end else if (mode_q != ST_RESETTING) begin
         rst_cnt_q <= 3'h0;
      end else if (rst_cnt_q != 3'(RESET_CYC - 1)) begin
         rst_cnt_q <= rst_cnt_q + 3'h1;
      end
   end

   // ==========================================================
   // Channel enables are latched only outside standby, so writes made
   // in standby wait until wakeup or lock takes the device out of standby
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         chan_enable_q <= 8'h00;
      end else if (mode_q != ST_STANDBY) begin
         chan_enable_q <= chan_shadow_q; // [RULE13]
      end
   end

   // Local copy of the enable register, so the freeze above needs no path into storage
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         chan_shadow_q <= 8'h00;
      end else if (soft_rst) begin
         chan_shadow_q <= 8'h00;
      end else if (wr_en && cmd_addr == ADDR_CHAN) begin
         chan_shadow_q <= cmd[7:0];
      end
   end

   // ==========================================================
   // Outputs
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         resp_word   <= 32'h0000_0000;
         single_word <= 1'b1;
         conv_run    <= 1'b0;
         chan_enable <= 8'h00;
         locked      <= 1'b0;
      end else begin
         resp_word   <= {resp_d, 16'h0000}; // [RULE1] [RULE25]
         single_word <= (mode_d == ST_READY) || (mode_d == ST_RESETTING); // [RULE3]
         conv_run    <= (mode_d == ST_ACTIVE) || (mode_d == ST_LOCKED); // [RULE12]
         chan_enable <= chan_enable_q;
         locked      <= (mode_d == ST_LOCKED);
      end
   end

   // ==========================================================
   // Checks
   a_ready_word: assert property (@(posedge clock) disable iff (!rstn) // [RULE2]
      (mode_q == ST_RESETTING && mode_d == ST_READY)
      |=> resp_word[31:16] == {READY_HI, DEVICE_ID})
      else $error("ready word not shown");

   a_null_fault: assert property (@(posedge clock) disable iff (!rstn) // [RULE7]
      (frame_end && mode_q == ST_ACTIVE && mr_left_q == 9'h000 && cmd == CMD_NULL)
      |=> resp_word[31:24] == {PFX_READ, ADDR_FAULT})
      else $error("null did not read fault register");

   a_standby_ack: assert property (@(posedge clock) disable iff (!rstn) // [RULE14]
      (frame_end && mode_q == ST_ACTIVE && mr_left_q == 9'h000 && cmd == CMD_STANDBY)
      |=> resp_word[31:16] == CMD_STANDBY && !conv_run)
      else $error("standby not acknowledged");

   a_wakeup_ack: assert property (@(posedge clock) disable iff (!rstn) // [RULE16]
      (frame_end && mode_q == ST_STANDBY && mr_left_q == 9'h000 && cmd == CMD_WAKEUP)
      |=> resp_word[31:16] == CMD_WAKEUP && conv_run)
      else $error("wakeup not acknowledged");

   a_lock_ack: assert property (@(posedge clock) disable iff (!rstn) // [RULE19]
      (frame_end && mode_q == ST_ACTIVE && mr_left_q == 9'h000 && cmd == CMD_LOCK)
      |=> resp_word[31:16] == CMD_LOCK && locked)
      else $error("lock not acknowledged");

   a_ready_gate: assert property (@(posedge clock) disable iff (!rstn) // [RULE4]
      (frame_end && mode_q == ST_READY && cmd != CMD_UNLOCK)
      |=> $stable(resp_word))
      else $error("ready state answered a command");

   a_lock_filter: assert property (@(posedge clock) disable iff (!rstn) // [RULE18]
      (frame_end && mode_q == ST_LOCKED && mr_left_q == 9'h000 && cmd == CMD_STANDBY)
      |=> locked)
      else $error("locked state took standby");

   a_multi_hold: assert property (@(posedge clock) disable iff (!rstn) // [RULE10]
      (frame_end && mr_left_q > 9'h002)
      |=> mr_left_q == $past(mr_left_q) - 9'h002)
      else $error("multi read not progressing");

   a_low_zero: assert property (@(posedge clock) disable iff (!rstn) // [RULE25]
      resp_word[15:0] == 16'h0000)
      else $error("low bits not zero");

   a_unlock_ack: assert property (@(posedge clock) disable iff (!rstn) // [RULE20]
      (frame_end && mode_q == ST_LOCKED && mr_left_q == 9'h000 && cmd == CMD_UNLOCK)
      |=> resp_word[31:16] == CMD_UNLOCK && !locked)
      else $error("unlock not acknowledged");

   a_ready_unlock: assert property (@(posedge clock) disable iff (!rstn) // [RULE4]
      (frame_end && mode_q == ST_READY && cmd == CMD_UNLOCK)
      |=> resp_word[31:16] == CMD_UNLOCK && !single_word)
      else $error("ready state did not take unlock");

   a_ready_single: assert property (@(posedge clock) disable iff (!rstn) // [RULE3]
      (frame_end && mode_q == ST_READY && cmd != CMD_UNLOCK)
      |=> single_word)
      else $error("ready frame not single word");

   a_lock_refuse: assert property (@(posedge clock) disable iff (!rstn) // [RULE19]
      (frame_end && mode_q == ST_LOCKED && mr_left_q == 9'h000 && !lock_ok(cmd))
      |=> resp_word[31:24] == {PFX_READ, ADDR_FAULT} && locked)
      else $error("refused command not answered with fault readback");

   a_reset_entry: assert property (@(posedge clock) disable iff (!rstn) // [RULE11]
      (frame_end && mode_q == ST_ACTIVE && mr_left_q == 9'h000 && cmd == CMD_RESET)
      |=> single_word && !conv_run)
      else $error("reset command not started");

   a_multi_first: assert property (@(posedge clock) disable iff (!rstn) // [RULE8]
      (frame_end && mode_q == ST_ACTIVE && mr_left_q == 9'h000 && is_multi(cmd))
      |=> resp_word[31:16] == {PFX_MULTI, $past(cmd[12:0])})
      else $error("multi read header wrong");

   a_read_echo: assert property (@(posedge clock) disable iff (!rstn) // [RULE22]
      (frame_end && mode_q == ST_ACTIVE && mr_left_q == 9'h000 && pfx == PFX_READ
       && !is_multi(cmd))
      |=> resp_word[31:24] == {PFX_READ, $past(cmd_addr)})
      else $error("single read address byte wrong");

   a_multi_pad: assert property (@(posedge clock) disable iff (!rstn) // [RULE8]
      (frame_end && mr_left_q == 9'h001)
      |=> resp_word[23:16] == 8'h00)
      else $error("odd multi read not padded");

   a_resp_hold: assert property (@(posedge clock) disable iff (!rstn) // [RULE23]
      (!frame_end && mode_q != ST_RESETTING)
      |=> $stable(resp_word))
      else $error("response changed without a frame end");

   a_chan_freeze: assert property (@(posedge clock) disable iff (!rstn) // [RULE13]
      (mode_q == ST_STANDBY && $past(mode_q) == ST_STANDBY)
      |=> $stable(chan_enable))
      else $error("channel enables changed in standby");
endmodule : cmd_responder
`default_nettype wire

// ---- host_model.sv ----
`default_nettype none
module host_model
   import cmd_resp_pkg::*;
(
   // Clock and device answer
   input  wire logic        clock,
   input  wire logic [31:0] resp_word,
   input  wire logic        single_word,
   // Frame to the device
   output var  logic        frame_end,
   output var  logic [31:0] cmd_word,
   output var  logic [1:0]  word_size
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      frame_end = 1'b0;
      cmd_word  = 32'h0;
      word_size = WS_16;
   end
   // One frame; the word is scrambled once released, so stale data never matches
   task automatic send(input logic [15:0] c);
      @(negedge clock);
      frame_end = 1'b1;
      cmd_word  = {c, 16'h0000};
      word_size = 2'($urandom_range(2));
      @(negedge clock);
      frame_end = 1'b0;
      cmd_word  = ~cmd_word;
      repeat (4) @(negedge clock);
   endtask : send
   // Poll for the ready word, then unlock
   task automatic wait_ready(output bit ok);
      ok = 1'b0;
      for (int i = 0; i < 200 && !ok; i++) begin
         @(negedge clock);
         ok = (resp_word[31:24] === READY_HI) && (single_word === 1'b1);
      end
      if (ok) send(CMD_UNLOCK);
   endtask : wait_ready
   task automatic standby_in();
      send({PFX_WRITE, 5'h0F, 8'h00});
      send(CMD_STANDBY);
   endtask : standby_in
   // Settle time stands in for the power-up wait of standby circuits
   task automatic standby_out(input logic [7:0] en);
      send({PFX_WRITE, 5'h0F, en});
      repeat (8) @(negedge clock);
      send(CMD_WAKEUP);
   endtask : standby_out
endmodule : host_model
`default_nettype wire

// ---- adc_spi_command_responder_bench.sv ----
`default_nettype none
module adc_spi_command_responder_bench import cmd_resp_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock, rstn, power_ok, frame_end, single_word, conv_run, locked;
   logic [1:0]  word_size;
   logic [31:0] cmd_word, resp_word;
   logic [7:0]  chan_enable, d, g;
   logic [7:0]  dflt [4];
   logic [63:0] exp_q [$];
   logic [1:0]  fe_pipe = 2'h0;
   int          err_total, n_compared;
   bit          ok;

   cmd_responder u_cmd_responder (.clock(clock), .rstn(rstn), .frame_end(frame_end),
      .cmd_word(cmd_word), .word_size(word_size), .power_ok(power_ok),
      .resp_word(resp_word), .single_word(single_word), .conv_run(conv_run),
      .chan_enable(chan_enable), .locked(locked));
   host_model u_host_model (.clock(clock), .resp_word(resp_word),
      .single_word(single_word), .frame_end(frame_end), .cmd_word(cmd_word),
      .word_size(word_size));

   initial clock = 1'b0;
   always #12.5 clock = ~clock;

   // ==========================================================
   // Compare tasks
   task automatic compare_resp(input logic [31:0] got, input logic [63:0] e);
      n_compared++;
      if ((got & e[63:32]) !== e[31:0]) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, e[31:0]);
      end
   endtask : compare_resp
   task automatic compare_out(input logic [31:0] got, input logic [31:0] e);
      n_compared++;
      if (got !== e) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, e);
      end
   endtask : compare_out
   task automatic note(input logic [15:0] e, input bit care);
      exp_q.push_back({care ? 32'hFFFFFFFF : 32'h0, e, 16'h0000});
   endtask : note
   task automatic tx(input logic [15:0] c, input logic [15:0] e);
      note(e, 1'b1);
      u_host_model.send(c);
   endtask : tx
   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_sim

   // ==========================================================
   // Response monitor: settled answer of each frame
   always @(posedge clock) fe_pipe <= {fe_pipe[0], frame_end};
   always @(negedge clock) begin
      if (fe_pipe[1]) begin
         compare_resp(resp_word, exp_q.size() ? exp_q.pop_front() : {32'hFFFFFFFF, 32'hx});
      end
   end

   initial begin
      #500000;
      err_total++;
      end_sim();
   end

   // ==========================================================
   // Tests
   initial begin
      d = 8'($urandom(32'hB3C2141F));
      dflt = '{RST_0B, RST_0C, RST_0D, RST_0E};
      err_total = 0;
      n_compared = 0;
      rstn = 1'b0;
      power_ok = 1'b0;
      repeat (4) @(negedge clock);
      rstn = 1'b1;
      repeat (10) @(negedge clock);
      compare_out(resp_word, 32'h0);
      power_ok = 1'b1;
      repeat (12) @(negedge clock);
      compare_out(resp_word, {READY_HI, DEVICE_ID, 16'h0000});
      compare_out(32'(single_word), 32'h1);
      tx(CMD_STANDBY, {READY_HI, DEVICE_ID});
      note(CMD_UNLOCK, 1'b1);
      u_host_model.wait_ready(ok);
      compare_out(32'({ok, single_word, conv_run, locked}), 32'hA);
      tx(CMD_NULL, {PFX_READ, ADDR_FAULT, 8'h00});
      tx({PFX_READ, 5'h00, 8'h00}, {PFX_READ, 5'h00, DEVICE_ID});
      tx({PFX_READ, 5'h01, 8'h00}, {PFX_READ, 5'h01, REV_ID});
      for (int i = 0; i < 4; i++) begin
         tx({PFX_READ, 5'(5'h0B + i), 8'h00}, {PFX_READ, 5'(5'h0B + i), dflt[i]});
      end
      g = 8'($urandom_range(7));
      tx({PFX_WRITE, 5'h14, g}, {PFX_READ, 5'h14, g});
      d = 8'($urandom_range(1, 15));
      tx({PFX_WRITE, 5'h0F, d}, {PFX_READ, 5'h0F, d});
      compare_out(32'(chan_enable), 32'(d));
      // Multi read past the last register; commands sent meanwhile are dropped
      tx({PFX_READ, 5'h13, 8'h02}, {PFX_MULTI, 5'h13, 8'h02});
      tx(CMD_STANDBY, {8'h00, g});
      tx(CMD_LOCK, 16'h0000);
      compare_out(32'({conv_run, locked}), 32'h2);
      tx(CMD_LOCK, CMD_LOCK);
      compare_out(32'(locked), 32'h1);
      tx(CMD_NULL, {PFX_READ, ADDR_FAULT, 8'h00});
      tx({PFX_WRITE, 5'h0F, ~d}, {PFX_READ, ADDR_FAULT, 8'h00});
      tx({PFX_READ, 5'h0F, 8'h00}, {PFX_READ, 5'h0F, d});
      tx(CMD_UNLOCK, CMD_UNLOCK);
      compare_out(32'(locked), 32'h0);
      // Standby: writes land in the register but enables wait for wakeup
      note({PFX_READ, 5'h0F, 8'h00}, 1'b1);
      note(CMD_STANDBY, 1'b1);
      u_host_model.standby_in();
      compare_out(32'(conv_run), 32'h0);
      tx({PFX_READ, 5'h14, 8'h00}, {PFX_READ, 5'h14, g});
      tx({PFX_WRITE, 5'h0F, d}, {PFX_READ, 5'h0F, d});
      compare_out(32'(chan_enable), 32'h0);
      note({PFX_READ, 5'h0F, d}, 1'b1);
      note(CMD_WAKEUP, 1'b1);
      u_host_model.standby_out(d);
      compare_out(32'({conv_run, chan_enable}), 32'({1'b1, d}));
      // Soft reset restores defaults and returns to the ready word
      note(16'h0000, 1'b0);
      u_host_model.send(CMD_RESET);
      repeat (12) @(negedge clock);
      compare_out(resp_word, {READY_HI, DEVICE_ID, 16'h0000});
      note(CMD_UNLOCK, 1'b1);
      u_host_model.wait_ready(ok);
      tx({PFX_READ, 5'h14, 8'h00}, {PFX_READ, 5'h14, 8'h00});
      tx({PFX_READ, 5'h0F, 8'h00}, {PFX_READ, 5'h0F, 8'h00});
      repeat (4) @(negedge clock);
      compare_out(32'(exp_q.size()), 32'h0);
      end_sim();
   end
endmodule : adc_spi_command_responder_bench
`default_nettype wire
